// File: core/usmc_pkg.sv
// Operation
// - Port clock keeps running in sleep when run_in_sleep set, else stops.
// - Running flag reads high while port active; software leaves mode alone then.
// - clock_source_sel picks reference, fast oscillator, system or peripheral bus clock.
// - overflow_continue set keeps receive shift register running after overrun.
// - overflow_continue clear stops receive shift register after overrun.
// - Port enable hands pins to port per pin_usage and transmit_enable.
// - Port disabled returns every pin to general-purpose control, minimal power.
// - stop_in_idle set halts port in idle; clear keeps it running.
// - infrared_enable routes transmit and receive through infrared encoder and decoder.
// - request_to_send_mode set gives simplex, clear gives flow control.
// - pin_usage 11 uses transmit, receive, baud clock; clear-to-send stays general-purpose.
// - pin_usage 10 uses transmit, receive, clear-to-send and request-to-send.
// - pin_usage 01 uses transmit, receive and request-to-send only.
// - pin_usage 00 uses only transmit and receive pins.
// - Wake field set makes start bit during sleep wake the device.
// - loopback_sel feeds transmitted output back into own receiver.
// - auto_baud measures next character, which remote sends as 0x55.
// - Hardware clears auto_baud once measurement finishes.
// - Mode bits 31-24 and 21-19 read as zero.
// - speed_sel set gives 4x baud clock, clear gives 16x.
// - framing_sel: 11 nine-bit, 10 odd parity, 01 even parity, 00 none.
// - stop_count_sel set gives two stop bits, clear gives one.
package usmc_pkg;

  localparam logic [3:0]  USMC_OFS_MODE    = 4'h0;
  localparam logic [3:0]  USMC_OFS_STATUS  = 4'h4;
  localparam logic [31:0] USMC_MODE_RESET  = 32'h0000_0000;
  localparam logic [31:0] USMC_MODE_WMASK  = 32'h0087_BBFF;

  localparam int USMC_BIT_SLEEP_RUN = 23;
  localparam int USMC_BIT_ACTIVE    = 22;
  localparam int USMC_BIT_CLOCK_SOURCE_SEL_LO = 17;
  localparam int USMC_BIT_OVF_CONT  = 16;
  localparam int USMC_BIT_ENABLE    = 15;
  localparam int USMC_BIT_IDLE_STOP = 13;
  localparam int USMC_BIT_INFRARED  = 12;
  localparam int USMC_BIT_RTS_MODE  = 11;
  localparam int USMC_BIT_PINUSE_LO = 8;
  localparam int USMC_BIT_WAKE      = 7;
  localparam int USMC_BIT_LOOPBACK  = 6;
  localparam int USMC_BIT_AUTOBAUD  = 5;
  localparam int USMC_BIT_RX_INVERT = 4;
  localparam int USMC_BIT_SPEED     = 3;
  localparam int USMC_BIT_FRAME_LO  = 1;
  localparam int USMC_BIT_STOP2     = 0;

  localparam logic [4:0] USMC_OSR_HIGH  = 5'h04;
  localparam logic [4:0] USMC_OSR_STD   = 5'h10;
  localparam logic [7:0] USMC_SYNC_CHAR = 8'h55;

  typedef enum logic [1:0] {
    USMC_CLK_PBUS,
    USMC_CLK_SYS,
    USMC_CLK_FRC,
    USMC_CLK_REFO
  } usmc_clk_e;

  typedef enum logic [1:0] {
    USMC_PIN_TXRX,
    USMC_PIN_RTS,
    USMC_PIN_HANDSHAKE,
    USMC_PIN_BCLK
  } usmc_pin_e;

  typedef struct packed {
    logic       nine_bit;
    logic       parity_en;
    logic       parity_odd;
    logic [1:0] stop_bits;
    logic [4:0] oversample;
    logic       rts_simplex;
    logic       auto_baud;
    logic       rx_invert;
  } usmc_cfg_s;

  typedef struct packed {
    logic cts;
    logic rts;
    logic bclk;
    logic tx;
    logic rx;
  } usmc_own_s;

endpackage : usmc_pkg

// File: core/usmc_mode_ctrl.sv
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
module usmc_mode_ctrl
  import usmc_pkg::*;
(
  input  wire logic        clk_i,          // 20 MHz system clock
  input  wire logic        rst_i,          // Synchronous reset, active high
  input  wire logic [3:0]  addr_i,         // Register byte address
  input  wire logic [31:0] wdata_i,        // Write data
  input  wire logic        wr_i,           // Write strobe
  input  wire logic        rd_i,           // Read strobe
  output logic      [31:0] rdata_o,        // Read data, cycle after rd_i
  input  wire logic        sleep_i,        // Device in sleep
  input  wire logic        idle_i,         // Device in idle
  input  wire logic        transmit_enable_i, // Transmitter enable from status reg
  input  wire logic        rx_overrun_i,   // Receive overrun flag from receiver
  input  wire logic        auto_baud_done_i,   // Baud measurement finished pulse
  input  wire logic        core_tx_i,      // Raw transmit bit from shifter
  input  wire logic        ir_tx_i,        // Infrared encoded transmit bit
  input  wire logic        ir_rx_i,        // Infrared decoded receive bit
  input  wire logic        core_rts_i,     // Request-to-send level from port
  input  wire logic        core_bclk_i,    // Baud clock from generator
  input  wire logic        gpio_tx_o_i,    // General-purpose level for tx pin
  input  wire logic        gpio_tx_oe_i,   // General-purpose enable for tx pin
  input  wire logic        gpio_rts_o_i,   // General-purpose level for rts pin
  input  wire logic        gpio_rts_oe_i,  // General-purpose enable for rts pin
  input  wire logic        serial_in_pin_i,   // Receive pin
  input  wire logic        clear_to_send_pin_i, // Clear-to-send pin
  output logic             serial_out_pin_o,  // Transmit pin level
  output logic             serial_out_pin_oe_o, // Transmit pin enable
  output logic             request_to_send_pin_o, // Rts or baud clock pin level
  output logic             request_to_send_pin_oe_o, // Rts or baud clock pin enable
  output logic             rx_to_core_o,   // Receive bit into shifter
  output logic             cts_to_core_o,  // Synced clear-to-send to port
  output logic             port_clk_en_o,  // Port clock gate enable
  output logic [1:0]       clk_src_sel_o,  // Port clock mux select
  output logic             shift_run_o,    // Receive shift register may run
  output logic             wake_o,         // Wake-up pulse
  output usmc_cfg_s        cfg_o,          // Frame and mode settings
  output usmc_own_s        own_o           // Pin ownership
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode register and field views

  logic [31:0] mode_r;
  logic [31:0] mode_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        clk_en_r;
  logic        shift_run_r;
  logic        wake_r;
  logic        rx_s1_r;
  logic        rx_s2_r;
  logic        rx_s3_r;
  logic        cts_s1_r;
  logic        cts_s2_r;
  logic        tx_pin_r;
  logic        tx_oe_r;
  logic        rts_pin_r;
  logic        rts_oe_r;
  logic        rx_core_r;
  logic        cts_core_r;
  usmc_cfg_s   cfg_r;
  usmc_cfg_s   cfg_nxt;
  usmc_own_s   own_r;
  usmc_own_s   own_nxt;

  wire         run_in_sleep      = mode_r[USMC_BIT_SLEEP_RUN];
  wire [1:0]   clock_source_sel  = mode_r[USMC_BIT_CLOCK_SOURCE_SEL_LO +: 2];
  wire         overflow_continue = mode_r[USMC_BIT_OVF_CONT];
  wire         port_enable       = mode_r[USMC_BIT_ENABLE];
  wire         stop_in_idle      = mode_r[USMC_BIT_IDLE_STOP];
  wire         infrared_enable   = mode_r[USMC_BIT_INFRARED];
  wire [1:0]   pin_usage         = mode_r[USMC_BIT_PINUSE_LO +: 2];
  wire         wake_enable       = mode_r[USMC_BIT_WAKE];
  wire         loopback_sel      = mode_r[USMC_BIT_LOOPBACK];
  wire         auto_baud         = mode_r[USMC_BIT_AUTOBAUD];
  wire         receive_invert    = mode_r[USMC_BIT_RX_INVERT];
  wire         speed_sel         = mode_r[USMC_BIT_SPEED];

  wire         sel_mode   = (addr_i == USMC_OFS_MODE);
  wire         sel_status = (addr_i == USMC_OFS_STATUS);
  wire         wr_mode    = wr_i && sel_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Clock gating: sleep, idle and enable

  // Sleep gate only bites when run_in_sleep is clear
  wire sleep_gate = sleep_i && !run_in_sleep;
  wire idle_gate  = idle_i && stop_in_idle;
  // Disabled port keeps its clock stopped to save power
  wire clk_en_nxt = port_enable && !sleep_gate && !idle_gate;

  // Running flag follows the live gate, not the request
  wire active_w   = clk_en_r;

  ////////////////////////////////////////////////////////////////////////////
  // Overflow policy

  // Legacy mode freezes the shifter until software clears the overrun
  wire shift_run_nxt = clk_en_nxt && (overflow_continue || !rx_overrun_i);

  ////////////////////////////////////////////////////////////////////////////
  // Mode register write and auto-baud self clear

  wire auto_baud_clear = auto_baud_done_i && auto_baud;

  always_comb begin
    mode_nxt = mode_r;
    if (auto_baud_clear) begin
      mode_nxt[USMC_BIT_AUTOBAUD] = 1'b0;
    end
    // Software write wins so a fresh request is never lost
    if (wr_mode) begin
      mode_nxt = wdata_i & USMC_MODE_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and start-bit wake

  wire rx_line    = rx_s2_r ^ receive_invert;
  wire start_edge = rx_s3_r && !rx_s2_r;
  wire wake_nxt   = sleep_i && wake_enable && start_edge;

  ////////////////////////////////////////////////////////////////////////////
  // Pin ownership and routing

  wire own_rts  = port_enable && (pin_usage == USMC_PIN_RTS
                                  || pin_usage == USMC_PIN_HANDSHAKE);
  wire own_bclk = port_enable && (pin_usage == USMC_PIN_BCLK);
  wire own_cts  = port_enable && (pin_usage == USMC_PIN_HANDSHAKE);
  wire own_tx   = port_enable && transmit_enable_i;

  // Encoder only sits in the path while infrared is on
  wire tx_bit   = infrared_enable ? ir_tx_i : core_tx_i;
  wire rx_bit   = infrared_enable ? ir_rx_i : rx_line;
  wire rx_route = loopback_sel ? tx_bit : rx_bit;

  wire tx_pin_nxt  = own_tx ? tx_bit : gpio_tx_o_i;
  wire tx_oe_nxt   = own_tx ? 1'b1 : gpio_tx_oe_i;
  wire rts_pin_nxt = own_bclk ? core_bclk_i
                   : own_rts ? core_rts_i : gpio_rts_o_i;
  wire rts_oe_nxt  = (own_bclk || own_rts) ? 1'b1 : gpio_rts_oe_i;
  // Unowned clear-to-send never holds off the transmitter
  wire cts_nxt     = own_cts && cts_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Registered decodes

  // Decoded from the incoming mode word, so cfg_o and own_o move with mode_r
  wire [31:0] mode_load  = rst_i ? USMC_MODE_RESET : mode_nxt;
  wire [1:0]  frame_load = mode_load[USMC_BIT_FRAME_LO +: 2];
  wire [1:0]  pins_load  = mode_load[USMC_BIT_PINUSE_LO +: 2];
  wire        on_load    = mode_load[USMC_BIT_ENABLE];

  always_comb begin
    cfg_nxt.nine_bit    = (frame_load == 2'h3);
    cfg_nxt.parity_en   = (frame_load == 2'h1) || (frame_load == 2'h2);
    cfg_nxt.parity_odd  = (frame_load == 2'h2);
    cfg_nxt.stop_bits   = mode_load[USMC_BIT_STOP2] ? 2'h2 : 2'h1;
    cfg_nxt.oversample  = mode_load[USMC_BIT_SPEED] ? USMC_OSR_HIGH : USMC_OSR_STD;
    cfg_nxt.rts_simplex = mode_load[USMC_BIT_RTS_MODE];
    // Receiver expects the sync character while this is set
    cfg_nxt.auto_baud   = mode_load[USMC_BIT_AUTOBAUD];
    cfg_nxt.rx_invert   = mode_load[USMC_BIT_RX_INVERT];
  end

  always_comb begin
    own_nxt.cts  = on_load && (pins_load == USMC_PIN_HANDSHAKE);
    own_nxt.rts  = on_load && (pins_load == USMC_PIN_RTS
                               || pins_load == USMC_PIN_HANDSHAKE);
    own_nxt.bclk = on_load && (pins_load == USMC_PIN_BCLK);
    own_nxt.tx   = on_load && transmit_enable_i;
    own_nxt.rx   = on_load;
  end

  always_ff @(posedge clk_i) begin
    cfg_r <= cfg_nxt;
    own_r <= own_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  wire [31:0] mode_view = (mode_r & ~(32'h1 << USMC_BIT_ACTIVE))
                        | ({31'h0000_0000, active_w} << USMC_BIT_ACTIVE);
  wire [31:0] status_view = {28'h000_0000, auto_baud, clk_en_r, shift_run_r,
                             rx_overrun_i};

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_i && sel_mode) begin
      rdata_nxt = mode_view;
    end else if (rd_i && sel_status) begin
      rdata_nxt = status_view;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r  <= USMC_MODE_RESET;
      rdata_r <= 32'h0000_0000;
    end else begin
      mode_r  <= mode_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_en_r    <= 1'b0;
      shift_run_r <= 1'b0;
      wake_r      <= 1'b0;
    end else begin
      clk_en_r    <= clk_en_nxt;
      shift_run_r <= shift_run_nxt;
      wake_r      <= wake_nxt;
    end
  end

  // Line idles high, so receive synchronisers reset high; clear-to-send ones reset low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_r  <= 1'b1;
      rx_s2_r  <= 1'b1;
      rx_s3_r  <= 1'b1;
      cts_s1_r <= 1'b0;
      cts_s2_r <= 1'b0;
    end else begin
      rx_s1_r  <= serial_in_pin_i;
      rx_s2_r  <= rx_s1_r;
      rx_s3_r  <= rx_s2_r;
      cts_s1_r <= clear_to_send_pin_i;
      cts_s2_r <= cts_s1_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_pin_r   <= 1'b1;
      tx_oe_r    <= 1'b0;
      rts_pin_r  <= 1'b0;
      rts_oe_r   <= 1'b0;
      rx_core_r  <= 1'b1;
      cts_core_r <= 1'b0;
    end else begin
      tx_pin_r   <= tx_pin_nxt;
      tx_oe_r    <= tx_oe_nxt;
      rts_pin_r  <= rts_pin_nxt;
      rts_oe_r   <= rts_oe_nxt;
      rx_core_r  <= rx_route;
      cts_core_r <= cts_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdata_o                  = rdata_r;
  assign serial_out_pin_o         = tx_pin_r;
  assign serial_out_pin_oe_o      = tx_oe_r;
  assign request_to_send_pin_o    = rts_pin_r;
  assign request_to_send_pin_oe_o = rts_oe_r;
  assign rx_to_core_o             = rx_core_r;
  assign cts_to_core_o            = cts_core_r;
  assign port_clk_en_o            = clk_en_r;
  assign clk_src_sel_o            = clock_source_sel;
  assign shift_run_o              = shift_run_r;
  assign wake_o                   = wake_r;

  assign cfg_o                    = cfg_r;
  assign own_o                    = own_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sleep_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_i && !run_in_sleep) |=> !port_clk_en_o)
    else $error("port clock ran in sleep without run_in_sleep");

  sleep_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_i && run_in_sleep && port_enable && !idle_gate && !wr_mode) |=> port_clk_en_o)
    else $error("port clock stopped in sleep with run_in_sleep");

  active_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && sel_mode) |=> (rdata_o[USMC_BIT_ACTIVE] == $past(port_clk_en_o)))
    else $error("running flag does not match port clock");

  clk_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mode |=> (clk_src_sel_o == $past(wdata_i[18:17])))
    else $error("clock source select not taken from write");

  ovf_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_overrun_i && !overflow_continue) |=> !shift_run_o)
    else $error("shifter kept running after overrun in legacy mode");

  ovf_cont_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_overrun_i && overflow_continue && clk_en_nxt) |=> shift_run_o)
    else $error("shifter stopped despite overflow_continue");

  off_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_enable |=> (serial_out_pin_oe_o == $past(gpio_tx_oe_i))
                     && (request_to_send_pin_oe_o == $past(gpio_rts_oe_i))
                     && !port_clk_en_o)
    else $error("disabled port still owns pins or clock");

  idle_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (idle_i && stop_in_idle) |=> !port_clk_en_o)
    else $error("port kept running in idle with stop_in_idle");

  ir_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (own_tx && infrared_enable) |=> (serial_out_pin_o == $past(ir_tx_i)))
    else $error("infrared encoder bypassed while enabled");

  hs_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_enable && pin_usage == 2'h2) |-> (own_o.cts && own_o.rts && !own_o.bclk))
    else $error("handshake pins not owned in code 10");

  bclk_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_enable && pin_usage == 2'h3) |=> (request_to_send_pin_o == $past(core_bclk_i))
                                           && !cts_to_core_o)
    else $error("baud clock pin not driven in code 11");

  rts_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_enable && pin_usage == 2'h1) |-> (own_o.rts && !own_o.cts && !own_o.bclk))
    else $error("pin ownership wrong in code 01");

  txrx_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_usage == 2'h0) |-> !(own_o.cts || own_o.rts || own_o.bclk))
    else $error("extra pins owned in code 00");

  wake_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_o |-> $past(sleep_i) && $past(wake_enable) && $past(rx_s3_r) && !$past(rx_s2_r))
    else $error("wake pulse without start bit in sleep");

  loop_feed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (loopback_sel && !infrared_enable) |=> (rx_to_core_o == $past(core_tx_i)))
    else $error("loopback did not feed transmit into receiver");

  auto_baud_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (auto_baud_done_i && auto_baud && !wr_mode) |=> !cfg_o.auto_baud)
    else $error("auto_baud not cleared after measurement");

  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && sel_mode) |=> (rdata_o[31:24] == 8'h00) && (rdata_o[21:19] == 3'h0))
    else $error("reserved mode bits read non-zero");

  osr_speed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_o.oversample == (speed_sel ? 5'h04 : 5'h10))
    else $error("oversample ratio does not follow speed_sel");

  frame_odd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mode && (wdata_i[2:1] == 2'h2) |=> cfg_o.parity_en && cfg_o.parity_odd
                                          && !cfg_o.nine_bit)
    else $error("framing code 10 not odd parity");

  stop_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mode |=> (cfg_o.stop_bits == ($past(wdata_i[0]) ? 2'h2 : 2'h1)))
    else $error("stop bit count does not follow stop_count_sel");

  tx_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (own_tx && !infrared_enable) |=> serial_out_pin_oe_o
                                     && (serial_out_pin_o == $past(core_tx_i)))
    else $error("transmit pin not driven by the port");

  ir_receive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (infrared_enable && !loopback_sel) |=> (rx_to_core_o == $past(ir_rx_i)))
    else $error("infrared decoder bypassed on receive");

  rts_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_enable && pin_usage == 2'h1) |=> request_to_send_pin_oe_o
                                           && (request_to_send_pin_o == $past(core_rts_i)))
    else $error("request-to-send pin not driven in code 01");

  rts_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!port_enable || pin_usage == 2'h0) |=> (request_to_send_pin_o == $past(gpio_rts_o_i))
                        && (request_to_send_pin_oe_o == $past(gpio_rts_oe_i)))
    else $error("request-to-send pin not returned to general-purpose control");

  cts_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!port_enable || pin_usage != 2'h2) |=> !cts_to_core_o)
    else $error("clear-to-send used while not owned");

  wake_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(sleep_i && wake_enable) |=> !wake_o)
    else $error("wake pulse outside sleep or with wake clear");

endmodule : usmc_mode_ctrl

// File: testbench/usmc_remote_model.sv
`timescale 1ns/1ps
module usmc_remote_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk_i,        // System clock
  input  wire logic tx_line_i,    // Line from the port, pulled up
  output logic      rx_line_o,    // Line into the port
  output logic      cts_line_o    // Handshake line into the port
);
  initial begin
    rx_line_o  = 1'b1;
    cts_line_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One frame, lsb first; mark level between frames
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rx_line_o <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask : send_char
  task automatic set_cts(input logic v);
    @(posedge clk_i);
    cts_line_o <= v;
  endtask : set_cts
endmodule : usmc_remote_model

// File: testbench/usmc_mode_ctrl_tb.sv
`timescale 1ns/1ps
module usmc_mode_ctrl_tb
  import usmc_pkg::*;
;
  localparam logic [31:0] EN = 32'h1 << USMC_BIT_ENABLE;
  localparam logic [31:0] ACT = 32'h1 << USMC_BIT_ACTIVE;
  logic clk_i = 1'b0;
  logic rst_i, wr_i, rd_i, sleep_i, idle_i, transmit_enable_i, rx_overrun_i, auto_baud_done_i;
  logic core_tx_i, ir_tx_i, ir_rx_i, core_rts_i, core_bclk_i, gpio_tx_o_i, gpio_tx_oe_i;
  logic gpio_rts_o_i, gpio_rts_oe_i, serial_in_pin_i, clear_to_send_pin_i;
  logic serial_out_pin_o, serial_out_pin_oe_o, request_to_send_pin_o, request_to_send_pin_oe_o;
  logic rx_to_core_o, cts_to_core_o, port_clk_en_o, shift_run_o, wake_o, tx_line;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [1:0]  clk_src_sel_o;
  usmc_cfg_s   cfg_o;
  usmc_own_s   own_o;
  int n_errors = 0;
  int n_compared = 0;
  int n_wake = 0;
  int wake_base = 0;

  always #25 clk_i = ~clk_i;
  // Released tx pin floats to the pull-up
  assign tx_line = serial_out_pin_oe_o ? serial_out_pin_o : 1'b1;
  always @(posedge clk_i) if (wake_o === 1'b1) n_wake <= n_wake + 1;

  usmc_mode_ctrl dut (
    .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sleep_i, .idle_i,
    .transmit_enable_i, .rx_overrun_i, .auto_baud_done_i, .core_tx_i, .ir_tx_i, .ir_rx_i,
    .core_rts_i, .core_bclk_i, .gpio_tx_o_i, .gpio_tx_oe_i, .gpio_rts_o_i, .gpio_rts_oe_i,
    .serial_in_pin_i, .clear_to_send_pin_i, .serial_out_pin_o, .serial_out_pin_oe_o,
    .request_to_send_pin_o, .request_to_send_pin_oe_o, .rx_to_core_o, .cts_to_core_o,
    .port_clk_en_o, .clk_src_sel_o, .shift_run_o, .wake_o, .cfg_o, .own_o
  );
  usmc_remote_model rm (
    .clk_i, .tx_line_i(tx_line), .rx_line_o(serial_in_pin_i), .cts_line_o(clear_to_send_pin_i)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 chk(rdata_o, e);
  endtask : rd
  // Port is switched off in the same write as the new fields and seen idle before the full word goes in
  // Five edges then cover the 2-FF pin sync plus the output register
  task automatic wm(input logic [31:0] d);
    int n;
    n = 0;
    wr(4'h0, d & ~EN);
    #1;
    while (port_clk_en_o !== 1'b0 && n < 8) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(port_clk_en_o, 0);
    if (port_clk_en_o !== 1'b0) test_done();
    wr(4'h0, d);
    repeat (5) @(posedge clk_i);
    #1;
  endtask : wm
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    test_done();
  end

  initial begin
    {rst_i, wr_i, rd_i, addr_i, wdata_i} = {1'b1, 38'h0};
    {sleep_i, idle_i, rx_overrun_i, auto_baud_done_i, ir_tx_i, ir_rx_i} = 6'h00;
    {transmit_enable_i, core_tx_i, core_rts_i, core_bclk_i} = 4'b1010;
    {gpio_tx_o_i, gpio_tx_oe_i, gpio_rts_o_i, gpio_rts_oe_i} = 4'b1000;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk({port_clk_en_o, serial_out_pin_oe_o, cfg_o.oversample}, {2'b00, USMC_OSR_STD});
    rd(4'h0, 32'h0);
    rd(4'hC, 32'h0);
    wm(32'hFFFF_FFFF);
    rd(4'h0, USMC_MODE_WMASK | ACT);
    chk(cfg_o.rx_invert, 1);
    for (int i = 0; i < 4; i++) begin
      wm(EN | (32'(i) << USMC_BIT_CLOCK_SOURCE_SEL_LO));
      chk(clk_src_sel_o, i);
      wm(EN | (32'(i) << USMC_BIT_PINUSE_LO));
      chk(own_o, {i == 2, i == 1 || i == 2, i == 3, 2'b11});
      chk({cts_to_core_o, request_to_send_pin_oe_o}, {i == 2, i != 0});
      chk(request_to_send_pin_o, i == 1 || i == 2);
      chk({serial_out_pin_o, serial_out_pin_oe_o}, 2'b01);
      wm(EN | (32'(i) << USMC_BIT_FRAME_LO));
      chk({cfg_o.nine_bit, cfg_o.parity_en, cfg_o.parity_odd}, {i == 3, i == 1 || i == 2, i == 2});
    end
    // Owned clear-to-send follows the pin through the synchroniser
    wm(EN | (32'h2 << USMC_BIT_PINUSE_LO));
    rm.set_cts(1'b0);
    repeat (4) @(posedge clk_i);
    #1 chk(cts_to_core_o, 0);
    rm.set_cts(1'b1);
    transmit_enable_i <= 1'b0;
    wm(EN);
    chk({own_o.tx, serial_out_pin_oe_o, cfg_o.stop_bits, cfg_o.rts_simplex}, 5'b00010);
    transmit_enable_i <= 1'b1;
    wm(32'h0000_0300);
    chk({own_o, serial_out_pin_o, serial_out_pin_oe_o, port_clk_en_o}, 8'h04);
    wm(EN | 32'h0000_0809);
    chk({cfg_o.oversample, cfg_o.stop_bits, cfg_o.rts_simplex}, {USMC_OSR_HIGH, 3'b101});
    // Sleep and idle gating of the port clock, then the overrun policy of the shifter
    sleep_i <= 1'b1;
    wm(EN);
    chk(port_clk_en_o, 0);
    wm(EN | (32'h1 << USMC_BIT_SLEEP_RUN));
    chk(port_clk_en_o, 1);
    {sleep_i, idle_i} <= 2'b01;
    wm(EN | (32'h1 << USMC_BIT_IDLE_STOP));
    chk(port_clk_en_o, 0);
    wm(EN);
    chk(port_clk_en_o, 1);
    idle_i <= 1'b0;
    rx_overrun_i <= 1'b1;
    wm(EN);
    chk(shift_run_o, 0);
    wm(EN | (32'h1 << USMC_BIT_OVF_CONT));
    chk(shift_run_o, 1);
    rx_overrun_i <= 1'b0;
    // Infrared path versus raw path, then loopback
    {ir_rx_i, ir_tx_i, core_tx_i} <= 3'b010;
    wm(EN | (32'h1 << USMC_BIT_INFRARED));
    chk({rx_to_core_o, serial_out_pin_o}, 2'b01);
    wm(EN);
    chk({rx_to_core_o, serial_out_pin_o}, 2'b10);
    wm(EN | (32'h1 << USMC_BIT_LOOPBACK));
    chk(rx_to_core_o, 0);
    core_tx_i <= 1'b1;
    wm(EN | (32'h1 << USMC_BIT_LOOPBACK));
    chk(rx_to_core_o, 1);
    // Start bit while asleep, with and without wake enabled, then auto-baud self clear
    sleep_i <= 1'b1;
    wm(EN | (32'h1 << USMC_BIT_WAKE));
    wake_base = n_wake;
    rm.send_char(8'h00);
    chk(n_wake - wake_base, 1);
    wm(EN);
    wake_base = n_wake;
    rm.send_char(8'h00);
    chk(n_wake - wake_base, 0);
    sleep_i <= 1'b0;
    wm(EN | (32'h1 << USMC_BIT_AUTOBAUD));
    chk(cfg_o.auto_baud, 1);
    rm.send_char(USMC_SYNC_CHAR);
    @(posedge clk_i);
    auto_baud_done_i <= 1'b1;
    @(posedge clk_i);
    auto_baud_done_i <= 1'b0;
    rd(4'h0, EN | ACT);
    chk(cfg_o.auto_baud, 0);
    rd(4'h4, 32'h0000_0006);
    // Second reset in mid-run
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk({own_o, port_clk_en_o, rx_to_core_o, cfg_o.auto_baud}, 8'h02);
    rd(4'h0, 32'h0);
    test_done();
  end
endmodule : usmc_mode_ctrl_tb
